// >>> capture_compare_pwm_unit.v
// Capture, compare and PWM units with an AHB-Lite register slave.
//
// Functional notes
// - Capture and compare use the 16-bit time base.
// - PWM runs from period timer a or b.
// - PWM base is timer value plus phase bits.
// - Duty is high register plus two low bits.
// - Mode zero disables and resets the unit.
// - Capture on falling, rising, 4th, 16th edge.
// - Mode 1000: start low, match drives high.
// - Mode 1001: start high, match drives low.
// - Mode 0010: output toggles on each match.
// - Mode 1010: flag only, pin left to port.
// - Mode 1011: match resets time base, flags.
// - Standard PWM is 1100; other codes reserved.
// - Enhanced PWM codes set pin pair polarity.
// - Non-PWM enhanced modes use only output a.
// - Single output mode follows steering enables.
// - Forward bridge: d modulated, a active.
// - Half bridge: a and b complementary pair.
// - Reverse bridge: b modulated, c active.
// - Large variant: one enhanced, two standard.
// - Timer select bit pairs timer a or b.
`timescale 1ns/100ps
`include "ccp_map.vh"

module capture_compare_pwm_unit #(
   parameter ENHANCED_VARIANT = 1
) (
   // Clock and reset.
   input  wire        hclk,
   input  wire        hresetn,
   // AHB-Lite slave.
   input  wire        hsel,
   input  wire [7:0]  haddr,
   input  wire [1:0]  htrans,
   input  wire        hwrite,
   input  wire [2:0]  hsize,
   input  wire        hready,
   input  wire [31:0] hwdata,
   output reg  [31:0] hrdata,
   output reg         hreadyout,
   output reg         hresp,
   // Time bases.
   input  wire [15:0] capture_time_base,
   input  wire [7:0]  period_timer_a,
   input  wire [1:0]  phase_a,
   input  wire        period_start_a,
   input  wire [7:0]  period_timer_b,
   input  wire [1:0]  phase_b,
   input  wire        period_start_b,
   output reg         time_base_reset,
   // Steering enables for pins a to d.
   input  wire [3:0]  steer_enable,
   // Unit pins; index 0 is enh_out_a on the enhanced variant.
   input  wire [2:0]  unit_pin_in,
   output reg  [2:0]  unit_pin_out,
   output reg  [2:0]  unit_pin_oe_n,
   // Extra enhanced pins.
   output reg         enh_out_b,
   output reg         enh_out_b_oe_n,
   output reg         enh_out_c,
   output reg         enh_out_c_oe_n,
   output reg         enh_out_d,
   output reg         enh_out_d_oe_n
);

   localparam NUM_UNITS = (ENHANCED_VARIANT != 0) ? 3 : 2;

   reg [15:0] ctrl_reg      [0:2];
   reg [15:0] value_reg     [0:2];
   reg [9:0]  duty_latch_reg[0:2];
   reg [3:0]  prev_mode_reg [0:2];
   reg [3:0]  presc_reg     [0:2];
   reg [2:0]  tsel_reg;
   reg [2:0]  flag_reg;
   reg [2:0]  pin_prev_reg;
   reg [2:0]  match_prev_reg;
   reg [2:0]  cmp_out_reg;
   reg [2:0]  pwm_reg;
   reg        wr_pend_reg;
   reg        rd_pend_reg;
   reg [7:0]  addr_reg;

   reg [2:0]  unit_on;
   reg [2:0]  cap_edge;
   reg [2:0]  cap_fire;
   reg [2:0]  cmp_hit;
   reg [2:0]  flag_clr;
   reg [3:0]  enh_out_next;
   reg [3:0]  enh_oe_n_next;
   reg [3:0]  m;
   reg [3:0]  ms;
   reg [3:0]  umode [0:2];
   integer    j;
   reg        pol_ac;
   reg        pol_bd;
   reg        p0;
   integer    i;

   function is_enh;
      input integer idx;
      begin
         is_enh = (ENHANCED_VARIANT != 0) && (idx == 0);
      end
   endfunction

   function is_pwm;
      input [3:0] mode;
      input       enh;
      begin
         if (enh) begin
            is_pwm = (mode[3:2] == 2'b11);
         end else begin
            is_pwm = (mode == `CCP_MODE_PWM);
         end
      end
   endfunction

   function is_reserved;
      input [3:0] mode;
      input       enh;
      begin
         is_reserved = (mode == `CCP_MODE_RSVD1) ||
                       (mode == `CCP_MODE_RSVD3) ||
                       (!enh && (mode >= `CCP_MODE_STD_RSVD));
      end
   endfunction

   function [9:0] pwm_base;
      input       sel;
      input [7:0] ta;
      input [1:0] pa;
      input [7:0] tb;
      input [1:0] pb;
      begin
         pwm_base = sel ? {tb, pb} : {ta, pa};
      end
   endfunction

   function is_compare;
      input [3:0] mode;
      begin
         is_compare = (mode == `CCP_MODE_TOGGLE) ||
                      (mode[3:2] == 2'b10);
      end
   endfunction

   // Per-unit event decode.
   always @* begin
      unit_on  = 3'b000;
      cap_edge = 3'b000;
      cap_fire = 3'b000;
      cmp_hit  = 3'b000;
      for (i = 0; i < 3; i = i + 1) begin
         m = ctrl_reg[i][`CCP_MODE_MSB:`CCP_MODE_LSB];
         umode[i] = m;
         unit_on[i] = (i < NUM_UNITS) && (m != `CCP_MODE_OFF) &&
                      !is_reserved(m, is_enh(i));
         case (m)
            `CCP_MODE_CAP_FALL: begin
               cap_edge[i] = !unit_pin_in[i] && pin_prev_reg[i];
               cap_fire[i] = cap_edge[i];
            end
            `CCP_MODE_CAP_RISE: begin
               cap_edge[i] = unit_pin_in[i] && !pin_prev_reg[i];
               cap_fire[i] = cap_edge[i];
            end
            `CCP_MODE_CAP_4TH: begin
               cap_edge[i] = unit_pin_in[i] && !pin_prev_reg[i];
               cap_fire[i] = cap_edge[i] &&
                             (presc_reg[i] == `CCP_PRESC_4TH);
            end
            `CCP_MODE_CAP_16TH: begin
               cap_edge[i] = unit_pin_in[i] && !pin_prev_reg[i];
               cap_fire[i] = cap_edge[i] &&
                             (presc_reg[i] == `CCP_PRESC_16TH);
            end
            default: begin
               cap_edge[i] = 1'b0;
               cap_fire[i] = 1'b0;
            end
         endcase
         // A match is taken once on its rising edge, since the time base
         // may rest on the compare value for many cycles.
         cmp_hit[i] = is_compare(m) && !match_prev_reg[i] &&
                      (capture_time_base == value_reg[i]);
         cap_fire[i] = cap_fire[i] && unit_on[i];
         cmp_hit[i]  = cmp_hit[i] && unit_on[i];
      end
   end

   // Flag clear from a bus write of ones to the flag register.
   always @* begin
      flag_clr = 3'b000;
      if (wr_pend_reg && (addr_reg == `CCP_FLAG_OFS)) begin
         flag_clr = hwdata[2:0];
      end
   end

   // Enhanced pin steering.
   always @* begin
      ms     = ctrl_reg[0][`CCP_MODE_MSB:`CCP_MODE_LSB];
      pol_ac = ms[1];
      pol_bd = ms[0];
      p0     = pwm_reg[0];
      enh_out_next  = 4'h0;
      enh_oe_n_next = 4'hF;
      if (unit_on[0] && is_pwm(ms, 1'b1)) begin
         case (ctrl_reg[0][`CCP_BRIDGE_MSB:`CCP_BRIDGE_LSB])
            `CCP_BRIDGE_SINGLE: begin
               enh_out_next  = {p0 ^ pol_bd, p0 ^ pol_ac,
                                p0 ^ pol_bd, p0 ^ pol_ac};
               enh_oe_n_next = ~steer_enable;
            end
            `CCP_BRIDGE_FWD: begin
               enh_out_next  = {p0 ^ pol_bd, pol_ac,
                                pol_bd, !pol_ac};
               enh_oe_n_next = 4'h0;
            end
            `CCP_BRIDGE_HALF: begin
               enh_out_next  = {2'b00, !p0 ^ pol_bd, p0 ^ pol_ac};
               enh_oe_n_next = 4'hC;
            end
            `CCP_BRIDGE_REV: begin
               enh_out_next  = {pol_bd, !pol_ac,
                                p0 ^ pol_bd, pol_ac};
               enh_oe_n_next = 4'h0;
            end
            default: begin
               enh_out_next  = 4'h0;
               enh_oe_n_next = 4'hF;
            end
         endcase
      end else begin
         enh_out_next[0]  = cmp_out_reg[0];
         enh_oe_n_next[0] = !(unit_on[0] &&
                              ((ms == `CCP_MODE_TOGGLE) ||
                               (ms == `CCP_MODE_CMP_HIGH) ||
                               (ms == `CCP_MODE_CMP_LOW)));
      end
   end

   // Unit logic, register file and pins.
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         for (j = 0; j < 3; j = j + 1) begin
            ctrl_reg[j]       <= `CCP_CTRL_RESET;
            value_reg[j]      <= `CCP_VALUE_RESET;
            duty_latch_reg[j] <= 10'h000;
            prev_mode_reg[j]  <= `CCP_MODE_OFF;
            presc_reg[j]      <= 4'h0;
         end
         tsel_reg        <= 3'b000;
         flag_reg        <= 3'b000;
         pin_prev_reg    <= 3'b000;
         match_prev_reg  <= 3'b000;
         cmp_out_reg     <= 3'b000;
         pwm_reg         <= 3'b000;
         time_base_reset <= 1'b0;
         unit_pin_out    <= 3'b000;
         unit_pin_oe_n   <= 3'b111;
         enh_out_b       <= 1'b0;
         enh_out_b_oe_n  <= 1'b1;
         enh_out_c       <= 1'b0;
         enh_out_c_oe_n  <= 1'b1;
         enh_out_d       <= 1'b0;
         enh_out_d_oe_n  <= 1'b1;
      end else begin
         pin_prev_reg    <= unit_pin_in;
         time_base_reset <= 1'b0;
         // Set wins over a clear in the same cycle.
         flag_reg <= (flag_reg & ~flag_clr) | cap_fire | cmp_hit;
         if (wr_pend_reg && (addr_reg == `CCP_TSEL_OFS)) begin
            tsel_reg <= {hwdata[`CCP_TSEL_BIT2], hwdata[`CCP_TSEL_BIT1],
                         hwdata[`CCP_TSEL_BIT0]};
         end
         for (j = 0; j < 3; j = j + 1) begin
            if (wr_pend_reg && (j < NUM_UNITS) &&
                (addr_reg == `CCP_CTRL0_OFS + 8'h04 * j[7:0])) begin
               ctrl_reg[j] <= hwdata[15:0] & (is_enh(j) ?
                              `CCP_ENH_CTRL_MASK : `CCP_STD_CTRL_MASK);
            end
            if (cap_fire[j]) begin
               value_reg[j] <= capture_time_base;
            end else if (wr_pend_reg && (j < NUM_UNITS) &&
                (addr_reg == `CCP_VALUE0_OFS + 8'h04 * j[7:0])) begin
               value_reg[j] <= hwdata[15:0];
            end
            prev_mode_reg[j] <= umode[j];
            if (!unit_on[j]) begin
               presc_reg[j]      <= 4'h0;
               match_prev_reg[j] <= 1'b0;
               cmp_out_reg[j]    <= 1'b0;
               pwm_reg[j]        <= 1'b0;
               duty_latch_reg[j] <= 10'h000;
            end else begin
               match_prev_reg[j] <= (capture_time_base == value_reg[j]);
               if (cap_fire[j]) begin
                  presc_reg[j] <= 4'h0;
               end else if (cap_edge[j]) begin
                  presc_reg[j] <= presc_reg[j] + 4'h1;
               end
               case (umode[j])
                  `CCP_MODE_CMP_HIGH: begin
                     if (umode[j] != prev_mode_reg[j]) begin
                        cmp_out_reg[j] <= 1'b0;
                     end else if (cmp_hit[j]) begin
                        cmp_out_reg[j] <= 1'b1;
                     end
                  end
                  `CCP_MODE_CMP_LOW: begin
                     if (umode[j] != prev_mode_reg[j]) begin
                        cmp_out_reg[j] <= 1'b1;
                     end else if (cmp_hit[j]) begin
                        cmp_out_reg[j] <= 1'b0;
                     end
                  end
                  `CCP_MODE_TOGGLE: begin
                     if (cmp_hit[j]) begin
                        cmp_out_reg[j] <= !cmp_out_reg[j];
                     end
                  end
                  `CCP_MODE_CMP_TBRST: begin
                     if (cmp_hit[j]) begin
                        time_base_reset <= 1'b1;
                     end
                  end
                  default: begin
                     cmp_out_reg[j] <= cmp_out_reg[j];
                  end
               endcase
               if (is_pwm(umode[j], is_enh(j))) begin
                  if (tsel_reg[j] ? period_start_b : period_start_a) begin
                     // Duty is latched here so a bus write mid-period
                     // never produces a runt pulse.
                     duty_latch_reg[j] <= {value_reg[j][7:0],
                        ctrl_reg[j][`CCP_DLOW_MSB:`CCP_DLOW_LSB]};
                     pwm_reg[j] <= ({value_reg[j][7:0], ctrl_reg[j]
                        [`CCP_DLOW_MSB:`CCP_DLOW_LSB]} != 10'h000);
                  end else if (pwm_base(tsel_reg[j], period_timer_a,
                     phase_a, period_timer_b, phase_b) ==
                     duty_latch_reg[j]) begin
                     pwm_reg[j] <= 1'b0;
                  end
               end else begin
                  pwm_reg[j] <= 1'b0;
               end
            end
            if (!is_enh(j)) begin
               unit_pin_out[j]  <= is_pwm(umode[j], 1'b0) ? pwm_reg[j] :
                                   cmp_out_reg[j];
               unit_pin_oe_n[j] <= !(unit_on[j] &&
                  (is_pwm(umode[j], 1'b0) ||
                  (umode[j] == `CCP_MODE_TOGGLE) ||
                  (umode[j] == `CCP_MODE_CMP_HIGH) ||
                  (umode[j] == `CCP_MODE_CMP_LOW)));
            end
         end
         if (ENHANCED_VARIANT != 0) begin
            unit_pin_out[0]  <= enh_out_next[0];
            unit_pin_oe_n[0] <= enh_oe_n_next[0];
            enh_out_b        <= enh_out_next[1];
            enh_out_b_oe_n   <= enh_oe_n_next[1];
            enh_out_c        <= enh_out_next[2];
            enh_out_c_oe_n   <= enh_oe_n_next[2];
            enh_out_d        <= enh_out_next[3];
            enh_out_d_oe_n   <= enh_oe_n_next[3];
         end
      end
   end

   // Bus slave; reads take one wait state so that a write just before
   // is already visible.
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend_reg <= 1'b0;
         rd_pend_reg <= 1'b0;
         addr_reg    <= 8'h00;
         hrdata      <= 32'h0000_0000;
         hreadyout   <= 1'b1;
         hresp       <= 1'b0;
      end else begin
         hresp <= 1'b0;
         if (rd_pend_reg) begin
            rd_pend_reg <= 1'b0;
            hreadyout   <= 1'b1;
            case (addr_reg)
               `CCP_CTRL0_OFS:  hrdata <= {16'h0000, ctrl_reg[0]};
               `CCP_CTRL1_OFS:  hrdata <= {16'h0000, ctrl_reg[1]};
               `CCP_CTRL2_OFS:  hrdata <= {16'h0000, ctrl_reg[2]};
               `CCP_VALUE0_OFS: hrdata <= {16'h0000, value_reg[0]};
               `CCP_VALUE1_OFS: hrdata <= {16'h0000, value_reg[1]};
               `CCP_VALUE2_OFS: hrdata <= {16'h0000, value_reg[2]};
               `CCP_TSEL_OFS:   hrdata <= {25'h0000000, tsel_reg[2], 2'b00,
                                           tsel_reg[1], 2'b00, tsel_reg[0]};
               `CCP_FLAG_OFS:   hrdata <= {29'h00000000, flag_reg};
               default:         hrdata <= 32'h0000_0000;
            endcase
         end
         wr_pend_reg <= 1'b0;
         if (hsel && htrans[1] && hready && hreadyout) begin
            addr_reg    <= haddr;
            wr_pend_reg <= hwrite;
            rd_pend_reg <= !hwrite;
            hreadyout   <= hwrite;
         end
      end
   end

endmodule

// >>> capture_compare_pwm_unit_props.sv
// Port assertions for the capture, compare and PWM unit.
`timescale 1ns/100ps
module capture_compare_pwm_unit_props (
   // Clock and reset.
   input wire logic        hclk,
   input wire logic        hresetn,
   // Register bus.
   input wire logic        hsel,
   input wire logic [1:0]  htrans,
   input wire logic        hwrite,
   input wire logic        hready,
   input wire logic [31:0] hrdata,
   input wire logic        hreadyout,
   input wire logic        hresp,
   // Unit outputs.
   input wire logic        time_base_reset,
   input wire logic [2:0]  unit_pin_out,
   input wire logic [2:0]  unit_pin_oe_n,
   input wire logic        enh_out_b_oe_n,
   input wire logic        enh_out_c_oe_n,
   input wire logic        enh_out_d_oe_n
);
   wire logic req    = hsel & htrans[1] & hready & hreadyout;
   wire logic rd_req = req & ~hwrite;

   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);

   a_resp_okay: assert property (hresp == 1'b0)
      else $error("bus response not okay");
   a_reset_idle: assert property ($rose(hresetn) |->
      unit_pin_oe_n == 3'h7 && unit_pin_out == 3'h0 && enh_out_b_oe_n
      && enh_out_c_oe_n && enh_out_d_oe_n && !time_base_reset && hreadyout)
      else $error("outputs not idle after reset");
   a_read_stall: assert property (rd_req |=> !hreadyout ##1 hreadyout)
      else $error("read wait state wrong");
   a_write_nowait: assert property (req && hwrite |=> hreadyout)
      else $error("write stalled");
   a_idle_ready: assert property (!(hsel && htrans[1]) && hreadyout
      |=> hreadyout)
      else $error("stall without request");
   a_wait_cause: assert property ($fell(hreadyout) |-> $past(rd_req))
      else $error("stall not caused by read");
   a_rdata_hold: assert property (hreadyout && $past(hreadyout)
      |-> $stable(hrdata))
      else $error("read data changed outside a read");
   a_tbrst_pulse: assert property (
      time_base_reset |=> !time_base_reset)
      else $error("time base reset longer than one cycle");
endmodule

// >>> ccp_map.vh
// Register offsets, field positions, mode codes and reset values.
`ifndef CCP_MAP_VH
`define CCP_MAP_VH

`define CCP_CTRL0_OFS        8'h00
`define CCP_CTRL1_OFS        8'h04
`define CCP_CTRL2_OFS        8'h08
`define CCP_VALUE0_OFS       8'h0C
`define CCP_VALUE1_OFS       8'h10
`define CCP_VALUE2_OFS       8'h14
`define CCP_TSEL_OFS         8'h18
`define CCP_FLAG_OFS         8'h1C

`define CCP_MODE_MSB         3
`define CCP_MODE_LSB         0
`define CCP_DLOW_MSB         5
`define CCP_DLOW_LSB         4
`define CCP_BRIDGE_MSB       7
`define CCP_BRIDGE_LSB       6
`define CCP_STD_CTRL_MASK    16'h003F
`define CCP_ENH_CTRL_MASK    16'h00FF
`define CCP_TSEL_BIT0        0
`define CCP_TSEL_BIT1        3
`define CCP_TSEL_BIT2        6

`define CCP_CTRL_RESET       16'h0000
`define CCP_VALUE_RESET      16'h0000

`define CCP_MODE_OFF         4'h0
`define CCP_MODE_RSVD1       4'h1
`define CCP_MODE_TOGGLE      4'h2
`define CCP_MODE_RSVD3       4'h3
`define CCP_MODE_CAP_FALL    4'h4
`define CCP_MODE_CAP_RISE    4'h5
`define CCP_MODE_CAP_4TH     4'h6
`define CCP_MODE_CAP_16TH    4'h7
`define CCP_MODE_CMP_HIGH    4'h8
`define CCP_MODE_CMP_LOW     4'h9
`define CCP_MODE_CMP_FLAG    4'hA
`define CCP_MODE_CMP_TBRST   4'hB
`define CCP_MODE_PWM         4'hC
`define CCP_MODE_STD_RSVD    4'hD

`define CCP_BRIDGE_SINGLE    2'h0
`define CCP_BRIDGE_FWD       2'h1
`define CCP_BRIDGE_HALF      2'h2
`define CCP_BRIDGE_REV       2'h3

`define CCP_PRESC_4TH        4'h3
`define CCP_PRESC_16TH       4'hF

`endif

// >>> pin_partner.sv
// Pin partner: capture sources and port drivers on the unit pins.
`timescale 1ns/100ps
module pin_partner (
   // Unit side.
   input  wire logic [2:0] pin_out,
   input  wire logic [2:0] pin_oe_n,
   // Source levels and resolved pins.
   input  wire logic [2:0] src,
   output wire logic [2:0] pin_in
);
   // A released pin shows the outside source, never a stale unit level.
   assign pin_in = (pin_out & ~pin_oe_n) | (src & pin_oe_n);
endmodule

// >>> test_capture_compare_pwm_unit.sv
// Self-checking bench for the capture, compare and PWM unit.
`timescale 1ns/100ps
`include "ccp_map.vh"
module test_capture_compare_pwm_unit;
   logic        hclk    = 1'h0;
   logic        hresetn = 1'h0;
   logic        hsel    = 1'h0;
   logic [7:0]  haddr   = 8'h00;
   logic [1:0]  htrans  = 2'h0;
   logic        hwrite  = 1'h0;
   logic [31:0] hwdata  = 32'h0;
   logic [15:0] tbase   = 16'h0;
   logic [3:0]  steer   = 4'h0;
   logic [2:0]  src     = 3'h0;
   logic [9:0]  cnt_a   = 10'h0;
   logic [9:0]  cnt_b   = 10'h0;
   logic        rd_ph   = 1'h0;
   logic [31:0] exp_q[$];
   wire  [31:0] hrdata;
   wire         hreadyout, hresp, tbr, b, boe, c, coe, d, doe;
   wire  [2:0]  pin_in, pin_out, pin_oe_n;
   wire  [5:0]  allv  = {d, c, b, pin_out};
   wire  [5:0]  alloe = {doe, coe, boe, pin_oe_n};
   int          num_errors = 0;
   int          n_checks = 0;
   int          n_tbr = 0;
   int          cyc = 0;

   always #2.5 hclk = ~hclk;

   // Period timers: 64 and 128 cycles of {timer, phase}.
   always @(posedge hclk) begin
      cnt_a <= (cnt_a == 10'h03F) ? 10'h000 : cnt_a + 10'h001;
      cnt_b <= (cnt_b == 10'h07F) ? 10'h000 : cnt_b + 10'h001;
   end

   capture_compare_pwm_unit dut (.hclk(hclk), .hresetn(hresetn),
      .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(3'h2), .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .capture_time_base(tbase),
      .period_timer_a(cnt_a[9:2]), .phase_a(cnt_a[1:0]),
      .period_start_a(cnt_a == 10'h000), .period_timer_b(cnt_b[9:2]),
      .phase_b(cnt_b[1:0]), .period_start_b(cnt_b == 10'h000),
      .time_base_reset(tbr), .steer_enable(steer), .unit_pin_in(pin_in),
      .unit_pin_out(pin_out), .unit_pin_oe_n(pin_oe_n), .enh_out_b(b),
      .enh_out_b_oe_n(boe), .enh_out_c(c), .enh_out_c_oe_n(coe),
      .enh_out_d(d), .enh_out_d_oe_n(doe));

   pin_partner pins (.pin_out(pin_out), .pin_oe_n(pin_oe_n), .src(src),
      .pin_in(pin_in));

   task automatic wrap_up;
      if (num_errors == 0 && n_checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] e,
                      input logic [31:0] g);
      n_checks++;
      if (g !== e) begin
         num_errors++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask

   // Read data are compared here, in the order the reads were issued.
   always @(posedge hclk) begin
      cyc <= cyc + 1;
      if (tbr === 1'h1)
         n_tbr <= n_tbr + 1;
      if (rd_ph && hreadyout === 1'h1) begin
         rd_ph <= 1'h0;
         chk("hrdata", exp_q.pop_front(), hrdata);
      end
      if (hsel && htrans[1] && !hwrite && hreadyout === 1'h1)
         rd_ph <= 1'h1;
      if (cyc == 40000) begin
         num_errors++;
         wrap_up();
      end
   end

   task automatic bus(input logic [7:0] a, input logic w,
                      input logic [31:0] dt);
      @(posedge hclk);
      hsel <= 1'h1;
      htrans <= 2'h2;
      haddr <= a;
      hwrite <= w;
      do @(posedge hclk); while (hreadyout !== 1'h1);
      hsel <= 1'h0;
      htrans <= 2'h0;
      hwdata <= dt;
      do @(posedge hclk); while (hreadyout !== 1'h1);
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] dt);
      bus(a, 1'h1, dt);
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      exp_q.push_back(e);
      bus(a, 1'h0, 32'h0);
   endtask

   task automatic meas(input int p, input int ch, output int n);
      n = 0;
      repeat (p) begin
         @(posedge hclk);
         if (allv[ch] === 1'h1)
            n++;
      end
   endtask

   function automatic int kind(input int br, input int ch);
      case (br)
         1: return ch == 0 ? 2 : ch == 3 ? 0 : 3;
         2: return ch == 0 ? 0 : ch == 1 ? 1 : 4;
         3: return ch == 1 ? 0 : ch == 2 ? 2 : 3;
         default: return 0;
      endcase
   endfunction

   initial begin
      int unsigned dummy;
      int          i, k, m, n, br, ch, pc, kd, e, dd, sel, hi, dl, t0;
      logic [15:0] base, v;
      logic        lvl, eoe;
      dummy = $urandom(32'h1112);
      repeat (3) @(posedge hclk);
      hresetn <= 1'h1;
      for (i = 0; i < 9; i++)
         rd(8'(i * 4), 32'h0);
      wr(`CCP_CTRL0_OFS, 32'hFFFFFFFF);
      rd(`CCP_CTRL0_OFS, 32'h000000FF);
      wr(`CCP_CTRL1_OFS, 32'hFFFFFFFF);
      rd(`CCP_CTRL1_OFS, 32'h0000003F);
      chk("rsvd_oe_n", 32'h1, {31'h0, alloe[1]});
      wr(`CCP_VALUE1_OFS, 32'hFFFFFFFF);
      rd(`CCP_VALUE1_OFS, 32'h0000FFFF);
      wr(`CCP_TSEL_OFS, 32'hFFFFFFFF);
      rd(`CCP_TSEL_OFS, 32'h00000049);
      wr(8'h20, 32'hFFFFFFFF);
      rd(8'h20, 32'h0);
      wr(`CCP_CTRL0_OFS, 32'h0);
      wr(`CCP_TSEL_OFS, 32'h0);
      wr(`CCP_FLAG_OFS, 32'h7);
      // Capture on unit 1; each edge carries its own time base value.
      for (m = 4; m < 8; m++) begin
         n = (m == 6) ? 4 : (m == 7) ? 16 : 1;
         base = 16'($urandom);
         wr(`CCP_CTRL1_OFS, 32'h0);
         wr(`CCP_CTRL1_OFS, 32'(m));
         for (k = 1; k <= n; k++) begin
            @(posedge hclk);
            src[1] <= 1'h1;
            if (m != 4)
               tbase <= base + 16'(k);
            repeat (4) @(posedge hclk);
            src[1] <= 1'h0;
            if (m == 4)
               tbase <= base + 16'(k);
            repeat (4) @(posedge hclk);
         end
         rd(`CCP_VALUE1_OFS, {16'h0, base + 16'(n)});
         rd(`CCP_FLAG_OFS, 32'h2);
         wr(`CCP_FLAG_OFS, 32'h2);
      end
      // Compare on unit 2, two matches per mode.
      for (i = 0; i < 5; i++) begin
         m = (i == 0) ? 2 : 7 + i;
         v = 16'($urandom);
         tbase <= ~v;
         wr(`CCP_CTRL2_OFS, 32'h0);
         wr(`CCP_VALUE2_OFS, {16'h0, v});
         wr(`CCP_CTRL2_OFS, 32'(m));
         repeat (3) @(posedge hclk);
         lvl = pin_out[2];
         if (m == 8 || m == 9)
            chk("entry", 32'(m == 9), {31'h0, lvl});
         chk("cmp_oe_n", 32'(m > 9), {31'h0, alloe[2]});
         for (k = 0; k < 2; k++) begin
            t0 = n_tbr;
            @(posedge hclk);
            tbase <= v;
            repeat (3) @(posedge hclk);
            tbase <= ~v;
            repeat (3) @(posedge hclk);
            lvl = (m == 2) ? ~lvl : (m == 8);
            if (m < 10)
               chk("cmp_pin", {31'h0, lvl}, {31'h0, pin_out[2]});
            chk("tb_reset", 32'(m == 11), 32'(n_tbr - t0));
         end
         rd(`CCP_FLAG_OFS, 32'h4);
         wr(`CCP_FLAG_OFS, 32'h4);
      end
      wr(`CCP_CTRL0_OFS, 32'h000000C8);
      repeat (3) @(posedge hclk);
      chk("enh_cmp_oe_n", 32'h38, {26'h0, alloe & 6'h39});
      // Standard PWM on unit 1; duty over 64 only fits timer b.
      for (i = 0; i < 4; i++) begin
         sel = i % 2;
         hi = (i == 0) ? 0 : sel ? 16 + $urandom % 15 : 1 + $urandom % 14;
         dl = (i == 0) ? 0 : $urandom % 4;
         wr(`CCP_TSEL_OFS, 32'(sel * 8));
         wr(`CCP_VALUE1_OFS, 32'(hi));
         wr(`CCP_CTRL1_OFS, 32'(dl * 16 + 12));
         repeat (256) @(posedge hclk);
         meas(sel ? 128 : 64, 1, n);
         chk("pwm_high", 32'(hi * 4 + dl), 32'(n));
         chk("pwm_oe_n", 32'h0, {31'h0, alloe[1]});
      end
      // Enhanced PWM: every polarity code with every bridge setting.
      wr(`CCP_TSEL_OFS, 32'h0);
      hi = 1 + $urandom % 14;
      dl = $urandom % 4;
      dd = hi * 4 + dl;
      wr(`CCP_VALUE0_OFS, 32'(hi));
      for (i = 0; i < 16; i++) begin
         m = 12 + i % 4;
         br = i / 4;
         steer <= 4'($urandom);
         wr(`CCP_CTRL0_OFS, 32'(br * 64 + dl * 16 + m));
         repeat (200) @(posedge hclk);
         for (ch = 0; ch < 4; ch++) begin
            pc = (ch == 0) ? 0 : ch + 2;
            kd = kind(br, ch);
            eoe = (kd == 4) || (br == 0 && !steer[ch]);
            chk("enh_oe_n", {31'h0, eoe}, {31'h0, alloe[pc]});
            if (!eoe) begin
               meas(64, pc, n);
               e = kd == 0 ? dd : kd == 1 ? 64 - dd : kd == 2 ? 64 : 0;
               if ((ch % 2 == 1) ? m[0] : m[1])
                  e = 64 - e;
               chk("enh_high", 32'(e), 32'(n));
            end
         end
      end
      wr(`CCP_CTRL0_OFS, 32'h0);
      wr(`CCP_CTRL1_OFS, 32'h0);
      repeat (3) @(posedge hclk);
      chk("off_oe_n", 32'h3F, {26'h0, alloe});
      wrap_up();
   end
endmodule

bind capture_compare_pwm_unit capture_compare_pwm_unit_props props (
   .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .htrans(htrans),
   .hwrite(hwrite), .hready(hready), .hrdata(hrdata),
   .hreadyout(hreadyout), .hresp(hresp), .time_base_reset(time_base_reset),
   .unit_pin_out(unit_pin_out), .unit_pin_oe_n(unit_pin_oe_n),
   .enh_out_b_oe_n(enh_out_b_oe_n), .enh_out_c_oe_n(enh_out_c_oe_n),
   .enh_out_d_oe_n(enh_out_d_oe_n));
